//--- ffm_pkg.sv
// Package for the free-fall/motion decision block
package ffm_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [6:0] OFS_COMMON_THS = 7'h17;
  localparam logic [6:0] OFS_DEBOUNCE_COUNT = 7'h18;
  localparam logic [6:0] OFS_X_THS_HIGH = 7'h73;
  localparam logic [6:0] OFS_X_THS_LOW = 7'h74;
  localparam logic [6:0] OFS_Y_THS_HIGH = 7'h75;
  localparam logic [6:0] OFS_Y_THS_LOW = 7'h76;
  localparam logic [6:0] OFS_Z_THS_HIGH = 7'h77;
  localparam logic [6:0] OFS_Z_THS_LOW = 7'h78;
  localparam int unsigned HIGH_EN_BIT = 7;
  localparam int unsigned CLR_MODE_BIT = 7;
  localparam int unsigned LOW_FIELD_W = 6;
  localparam int unsigned HIGH_FIELD_W = 7;
  localparam int unsigned AXIS_THS_W = 13;
  localparam int unsigned COMMON_THS_W = 7;
  localparam int unsigned COMMON_MG_PER_COUNT = 63;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int unsigned SYNC_STAGES = 3;
endpackage : ffm_pkg

//--- ffm_cmp_if.sv
// Interface carrying thresholds and samples to the comparator
`timescale 1ns/1ps
`default_nettype none
interface ffm_cmp_if #(parameter int unsigned DW = 14);
  logic [2:0][DW-1:0] mag;
  logic [2:0][12:0] ths;
  logic [2:0] axis_en;
  logic motion_mode;
  logic cond;
  modport top (output mag, output ths, output axis_en, output motion_mode, input cond);
  modport cmp (input mag, input ths, input axis_en, input motion_mode, output cond);
endinterface : ffm_cmp_if
`default_nettype wire

//--- ffm_cmp.sv
// Per-axis threshold comparison and and/or combination
`timescale 1ns/1ps
`default_nettype none
module ffm_cmp
  import ffm_pkg::*;
#(
  parameter int unsigned DW = 14
)
(
  ffm_cmp_if.cmp c // Comparison operands and result
);
  logic [2:0] below;
  logic [2:0] above;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_axis
      assign below[g] = ({1'b0, c.mag[g]} < {{(DW + 1 - 13){1'b0}}, c.ths[g]});
      assign above[g] = ({1'b0, c.mag[g]} > {{(DW + 1 - 13){1'b0}}, c.ths[g]});
    end
  endgenerate
  // No enabled axis means no event in either mode
  always_comb
  begin
    if (c.axis_en == 3'h0)
      c.cond = 1'b0;
    else if (c.motion_mode)
      c.cond = |(above & c.axis_en);
    else
      c.cond = &(below | ~c.axis_en);
  end
endmodule : ffm_cmp
`default_nettype wire

//--- ffm_top.sv
// Free-fall/motion threshold and debounce decision logic
// What this block does
// - Y threshold from low 5:0, high 12:6.
// - Z threshold from low 5:0, high 12:6.
// - Free-fall: all enabled axes below threshold.
// - Motion: any enabled axis above threshold.
// - Common threshold is unsigned seven bits.
// - Per-axis enable uses own 13-bit thresholds.
// - Eight-bit debounce count setting held.
// - Interrupt only after debounce count met.
// - Event flag set when counter equals setting.
// - Counter saturates at programmed count.
// - Counter steps once per sample period.
// - Clear-mode bit governs reaction to false.
// - Clear-mode 1 zeroes, 0 decrements counter.
// - Common threshold fixed at 63 mg/count.
`timescale 1ns/1ps
`default_nettype none
module ffm_top
  import ffm_pkg::*;
#(
  parameter int unsigned DW = 14, // Sample magnitude width
  parameter int unsigned COMMON_SHIFT = 8 // Common count to sample LSB scale, log2
)
(
  input wire logic ref_clk_i, // 200 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic clk_en_i, // Freezes registers, counter and event while low; reset synchronizer still runs
  input wire logic reg_wr_i, // Register write strobe
  input wire logic [6:0] reg_addr_i, // Register address
  input wire logic [7:0] reg_wdata_i, // Register write data
  output logic [7:0] reg_rdata_o, // Register read data
  input wire logic sample_valid_i, // New sample strobe, one per output sample rate
  input wire logic [DW-1:0] mag_x_i, // Absolute X acceleration
  input wire logic [DW-1:0] mag_y_i, // Absolute Y acceleration
  input wire logic [DW-1:0] mag_z_i, // Absolute Z acceleration
  input wire logic [2:0] axis_en_i, // Enabled axes, z y x
  input wire logic motion_mode_i, // 1 any above, 0 all below
  input wire logic dbc_clear_mode_i, // 1 clear, 0 decrement on false
  output logic [7:0] dbc_count_o, // Internal debounce counter
  output logic event_o, // Event flag, level
  output logic irq_o // Interrupt request, level
);
  initial
  begin
    if (DW < 13 || COMMON_SHIFT < 6 || COMMON_SHIFT > 16)
      $error("ffm_top: DW or COMMON_SHIFT unsupported");
  end

  logic [1:0] rst_sync;
  logic rst_n;
  logic [7:0] common_ths;
  logic [7:0] debounce_count;
  logic [7:0] x_high, x_low, y_high, y_low, z_high, z_low;
  logic [7:0] dbc;
  logic evt;
  logic [7:0] next_dbc;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  function automatic logic [12:0] join_ths(input logic [7:0] hi, input logic [7:0] lo);
    join_ths = {hi[HIGH_FIELD_W-1:0], lo[LOW_FIELD_W-1:0]};
  endfunction

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      common_ths <= REG_RESET;
      debounce_count <= REG_RESET;
      x_high <= REG_RESET;
      x_low <= REG_RESET;
      y_high <= REG_RESET;
      y_low <= REG_RESET;
      z_high <= REG_RESET;
      z_low <= REG_RESET;
    end
    else if (clk_en_i && reg_wr_i)
    begin
      case (reg_addr_i)
        OFS_COMMON_THS: common_ths <= reg_wdata_i;
        OFS_DEBOUNCE_COUNT: debounce_count <= reg_wdata_i;
        OFS_X_THS_HIGH: x_high <= reg_wdata_i;
        OFS_X_THS_LOW: x_low <= reg_wdata_i;
        OFS_Y_THS_HIGH: y_high <= reg_wdata_i;
        OFS_Y_THS_LOW: y_low <= reg_wdata_i;
        OFS_Z_THS_HIGH: z_high <= reg_wdata_i;
        OFS_Z_THS_LOW: z_low <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (reg_addr_i)
      OFS_COMMON_THS: reg_rdata_o = common_ths;
      OFS_DEBOUNCE_COUNT: reg_rdata_o = debounce_count;
      OFS_X_THS_HIGH: reg_rdata_o = x_high;
      OFS_X_THS_LOW: reg_rdata_o = x_low;
      OFS_Y_THS_HIGH: reg_rdata_o = y_high;
      OFS_Y_THS_LOW: reg_rdata_o = y_low;
      OFS_Z_THS_HIGH: reg_rdata_o = z_high;
      OFS_Z_THS_LOW: reg_rdata_o = z_low;
      default: reg_rdata_o = 8'h00;
    endcase
  end

  ffm_cmp_if #(.DW(DW)) cmp_bus ();
  localparam int unsigned CW = COMMON_THS_W + COMMON_SHIFT;
  logic per_axis;
  logic [12:0] common_scaled;
  logic [CW-1:0] common_wide;
  // software keeps the transient-threshold enable off while per-axis is on
  assign per_axis = x_high[HIGH_EN_BIT];
  // Common count has fixed weight, scaled to sample LSBs by a power of two
  assign common_wide = {common_ths[COMMON_THS_W-1:0], {COMMON_SHIFT{1'b0}}};
  // Counts beyond the 13-bit comparator reach saturate instead of wrapping to a tiny threshold
  assign common_scaled = (common_wide > CW'(13'h1FFF)) ? 13'h1FFF : common_wide[12:0];
  assign cmp_bus.mag[0] = mag_x_i;
  assign cmp_bus.mag[1] = mag_y_i;
  assign cmp_bus.mag[2] = mag_z_i;
  assign cmp_bus.ths[0] = per_axis ? join_ths(x_high, x_low) : common_scaled;
  assign cmp_bus.ths[1] = per_axis ? join_ths(y_high, y_low) : common_scaled;
  assign cmp_bus.ths[2] = per_axis ? join_ths(z_high, z_low) : common_scaled;
  assign cmp_bus.axis_en = axis_en_i;
  assign cmp_bus.motion_mode = motion_mode_i;

  ffm_cmp #(.DW(DW)) u_cmp (.c(cmp_bus));

  always_comb
  begin
    next_dbc = dbc;
    if (cmp_bus.cond)
    begin
      if (dbc < debounce_count)
        next_dbc = dbc + 8'h01;
      else
        next_dbc = debounce_count;
    end
    else if (dbc_clear_mode_i)
      next_dbc = 8'h00;
    else if (dbc != 8'h00)
      next_dbc = dbc - 8'h01;
  end

  // Counter only moves on a sample strobe, so its step tracks the sample rate
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      dbc <= 8'h00;
    else if (clk_en_i && sample_valid_i)
      dbc <= next_dbc;
  end

  // A zero setting raises the event on the first matching sample
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      evt <= 1'b0;
    else if (clk_en_i && sample_valid_i)
      evt <= cmp_bus.cond && (next_dbc == debounce_count);
  end

  assign dbc_count_o = dbc;
  assign event_o = evt;
  assign irq_o = evt;

  a_cnt_sat: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && cmp_bus.cond) |=> dbc <= $past(debounce_count))
    else $error("counter above setting after match");
  a_cnt_bound: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $changed(dbc) |-> dbc <= debounce_count || $past(dbc) > dbc)
    else $error("counter passed setting");
  a_cnt_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !$past(sample_valid_i && clk_en_i) |-> $stable(dbc))
    else $error("counter moved without sample");
  a_cnt_inc: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && cmp_bus.cond && dbc < debounce_count) |=> dbc == $past(dbc) + 8'h01)
    else $error("counter did not increment");
  a_cnt_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && !cmp_bus.cond && dbc_clear_mode_i) |=> dbc == 8'h00)
    else $error("counter not cleared");
  a_cnt_dec: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && !cmp_bus.cond && !dbc_clear_mode_i && dbc != 8'h00)
    |=> dbc == $past(dbc) - 8'h01)
    else $error("counter not decremented");
  a_evt_equal: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(evt) |-> dbc == debounce_count)
    else $error("event without full count");
  a_irq_evt: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    irq_o |-> event_o && dbc == debounce_count)
    else $error("interrupt before debounce");
  a_free_fall: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (!motion_mode_i && cmp_bus.cond) |-> !(axis_en_i[0] && mag_x_i >= DW'(cmp_bus.ths[0])))
    else $error("free-fall with X above");
  a_motion_any: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (motion_mode_i && axis_en_i[1] && mag_y_i > DW'(cmp_bus.ths[1])) |-> cmp_bus.cond)
    else $error("motion missed on Y");

  // Counter, event and interrupt guards
  a_sat_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && cmp_bus.cond && dbc >= debounce_count)
    |=> dbc == $past(debounce_count))
    else $error("counter left saturation");

  a_dec_floor: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && !cmp_bus.cond && dbc == 8'h00) |=> dbc == 8'h00)
    else $error("counter went below zero");

  a_freeze_dbc: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !clk_en_i |=> $stable(dbc))
    else $error("counter moved while frozen");

  a_freeze_evt: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !clk_en_i |=> $stable(evt))
    else $error("event moved while frozen");

  a_evt_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !(clk_en_i && sample_valid_i) |=> $stable(evt))
    else $error("event moved without sample");

  a_evt_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && sample_valid_i && !cmp_bus.cond) |=> !evt)
    else $error("event stayed after condition dropped");

  a_evt_cond: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $rose(evt) |-> $past(cmp_bus.cond))
    else $error("event rose without matching sample");

  a_irq_same: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    irq_o == event_o)
    else $error("interrupt differs from event");

  // Register and enable guards
  a_freeze_regs: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !clk_en_i |=> $stable(debounce_count))
    else $error("setting written while frozen");

  a_setting_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (clk_en_i && reg_wr_i && reg_addr_i == OFS_DEBOUNCE_COUNT)
    |=> debounce_count == $past(reg_wdata_i))
    else $error("setting write lost");

  a_read_setting: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (reg_addr_i == OFS_DEBOUNCE_COUNT) |-> reg_rdata_o == debounce_count)
    else $error("setting read wrong");

  // Threshold selection guards
  a_x_join: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    per_axis |-> cmp_bus.ths[0] == {x_high[6:0], x_low[5:0]})
    else $error("X threshold assembled wrong");

  a_y_join: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    per_axis |-> cmp_bus.ths[1] == {y_high[6:0], y_low[5:0]})
    else $error("Y threshold assembled wrong");

  a_z_join: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    per_axis |-> cmp_bus.ths[2] == {z_high[6:0], z_low[5:0]})
    else $error("Z threshold assembled wrong");

  a_common_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !per_axis |-> (cmp_bus.ths[0] == cmp_bus.ths[1] && cmp_bus.ths[1] == cmp_bus.ths[2]))
    else $error("common threshold not shared");

  // Comparison guards
  a_no_axis: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (axis_en_i == 3'h0) |-> !cmp_bus.cond)
    else $error("condition with no axis enabled");

  a_ff_y: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (!motion_mode_i && cmp_bus.cond) |-> !(axis_en_i[1] && mag_y_i >= DW'(cmp_bus.ths[1])))
    else $error("free-fall with Y above");

  a_ff_z: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (!motion_mode_i && cmp_bus.cond) |-> !(axis_en_i[2] && mag_z_i >= DW'(cmp_bus.ths[2])))
    else $error("free-fall with Z above");

  a_ff_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (!motion_mode_i && axis_en_i != 3'h0
      && (!axis_en_i[0] || mag_x_i < DW'(cmp_bus.ths[0]))
      && (!axis_en_i[1] || mag_y_i < DW'(cmp_bus.ths[1]))
      && (!axis_en_i[2] || mag_z_i < DW'(cmp_bus.ths[2]))) |-> cmp_bus.cond)
    else $error("free-fall missed");

  a_motion_x: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (motion_mode_i && axis_en_i[0] && mag_x_i > DW'(cmp_bus.ths[0])) |-> cmp_bus.cond)
    else $error("motion missed on X");

  a_motion_none: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (motion_mode_i && cmp_bus.cond) |-> ((axis_en_i[0] && mag_x_i > DW'(cmp_bus.ths[0]))
      || (axis_en_i[1] && mag_y_i > DW'(cmp_bus.ths[1]))
      || (axis_en_i[2] && mag_z_i > DW'(cmp_bus.ths[2]))))
    else $error("motion without any axis above");
endmodule : ffm_top
`default_nettype wire

//--- ffm_host.sv
// Host model that writes and reads the decision block's registers
`timescale 1ns/1ps
`default_nettype none
module ffm_host
(
  input wire logic clk_i, // Block clock
  input wire logic [7:0] rdata_i, // Read data
  output logic wr_o = 1'b0, // Write strobe
  output logic [6:0] addr_o = 7'h00, // Register address
  output logic [7:0] wdata_o = 8'h00 // Write data
);
  // Callers never set both threshold enables together
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // Idle bus never shows the last value
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule // ffm_host
`default_nettype wire

//--- tb_ffm_top.sv
// Self-checking bench for the free-fall/motion decision block
`timescale 1ns/1ps
`default_nettype none
module tb_ffm_top;
  import ffm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wr, sv, mm, cm, evt, irq;
  logic [6:0] adr;
  logic [7:0] wd, rd, cnt, set, ec;
  logic [13:0] mx, my, mz;
  logic [2:0] en;
  int fail_count = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  ffm_host host (.clk_i(clk), .rdata_i(rd), .wr_o(wr), .addr_o(adr), .wdata_o(wd));
  ffm_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce), .reg_wr_i(wr),
    .reg_addr_i(adr), .reg_wdata_i(wd), .reg_rdata_o(rd), .sample_valid_i(sv),
    .mag_x_i(mx), .mag_y_i(my), .mag_z_i(mz), .axis_en_i(en), .motion_mode_i(mm),
    .dbc_clear_mode_i(cm), .dbc_count_o(cnt), .event_o(evt), .irq_o(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One sample, then the counter model steps and outputs are judged
  task automatic smp(input logic [13:0] x, y, z, input logic c);
    logic hit;
    @(negedge clk);
    sv = 1'b1;
    mx = x;
    my = y;
    mz = z;
    @(negedge clk);
    sv = 1'b0;
    mx = ~x;
    if (c && ec != set)
      ec = ec + 8'h01;
    else if (!c)
      ec = (cm || ec == 8'h00) ? 8'h00 : ec - 8'h01;
    hit = c && ec == set;
    chk(cnt, ec, "count");
    chk(evt, hit, "event");
    chk(irq, hit, "irq");
  endtask
  task automatic clr();
    cm = 1'b1;
    en = 3'b000;
    smp(14'h0000, 14'h0000, 14'h0000, 1'b0);
  endtask
  task automatic setc(input logic [7:0] v);
    host.wr(OFS_DEBOUNCE_COUNT, v);
    set = v;
  endtask
  task automatic t_regs();
    logic [7:0] d;
    host.rd(OFS_DEBOUNCE_COUNT, d);
    chk(d, REG_RESET, "count reset");
    host.rd(OFS_Z_THS_LOW, d);
    chk(d, REG_RESET, "z low reset");
    host.wr(OFS_DEBOUNCE_COUNT, 8'hA5);
    host.rd(OFS_DEBOUNCE_COUNT, d);
    chk(d, 8'hA5, "count rw");
    host.rd(7'h7F, d);
    chk(d, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_ff();
    clr();
    host.wr(OFS_COMMON_THS, 8'h02);
    setc(8'h03);
    cm = 1'b0;
    mm = 1'b0;
    en = 3'b111;
    repeat (4) smp(14'h01FF, 14'h0000, 14'h0064, 1'b1);
    smp(14'h0200, 14'h0000, 14'h0000, 1'b0);
    smp(14'h0000, 14'h0000, 14'h0000, 1'b1);
    en = 3'b011;
    smp(14'h0000, 14'h0000, 14'h3FFF, 1'b1);
    $display("test free-fall done");
  endtask
  task automatic t_mo();
    clr();
    setc(8'h02);
    mm = 1'b1;
    en = 3'b111;
    smp(14'h0000, 14'h0201, 14'h0000, 1'b1);
    smp(14'h0200, 14'h0200, 14'h0200, 1'b0);
    repeat (2) smp(14'h0000, 14'h0000, 14'h0201, 1'b1);
    en = 3'b100;
    smp(14'h3FFF, 14'h3FFF, 14'h0000, 1'b0);
    $display("test motion done");
  endtask
  // Per-axis values sit far below the common one, so a mix-up shows
  task automatic t_ax();
    clr();
    setc(8'h00);
    mm = 1'b1;
    host.wr(OFS_X_THS_HIGH, 8'h80);
    host.wr(OFS_Y_THS_HIGH, 8'h02);
    host.wr(OFS_Y_THS_LOW, 8'hFF);
    host.wr(OFS_Z_THS_HIGH, 8'h03);
    host.wr(OFS_Z_THS_LOW, 8'hC1);
    en = 3'b010;
    smp(14'h3FFF, 14'h00C0, 14'h3FFF, 1'b1);
    smp(14'h3FFF, 14'h00BF, 14'h3FFF, 1'b0);
    en = 3'b100;
    smp(14'h0000, 14'h0000, 14'h00C2, 1'b1);
    smp(14'h0000, 14'h0000, 14'h00C1, 1'b0);
    $display("test per-axis done");
  endtask
  // With the enable low, a write and a matching sample must both be ignored
  task automatic t_ce();
    logic [7:0] d;
    @(negedge clk);
    ce = 1'b0;
    host.wr(OFS_DEBOUNCE_COUNT, 8'h05);
    host.rd(OFS_DEBOUNCE_COUNT, d);
    chk(d, 8'h00, "frozen write");
    smp(14'h0000, 14'h0000, 14'h3FFF, 1'b0);
    ce = 1'b1;
    smp(14'h0000, 14'h0000, 14'h3FFF, 1'b1);
    $display("test enable done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    sv = 1'b0;
    mm = 1'b0;
    cm = 1'b1;
    en = 3'b000;
    {mx, my, mz} = '0;
    set = 8'h00;
    ec = 8'h00;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    t_ff();
    t_mo();
    t_ax();
    t_ce();
    give_verdict();
  end
  initial
  begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule // tb_ffm_top
`default_nettype wire
